// ==== cursor_ink_overlay.sv ====
// top: APB registers, overlay fetch and pixel mixing for the LCD and TV channels
// Operation
// - TV colour 0 stored as 5-bit blue, 6-bit green, 5-bit red bytes.
// - TV colour 1 stored in the same layout in three more bytes.
// - each channel has a 4-bit FIFO high threshold in bits 3..0.
// - fetch keeps overlay FIFO filled to the threshold during display.
// - threshold zero means hardware chooses the threshold itself.
// - each channel locates its image from its own start address register.
// - dual-panel buffer is width times height times factor over 16 bytes.
// - dual-panel buffer starts at memory size minus its size.
// - a cursor fetch is always exactly 1024 bytes.
// - an ink fetch is width times height over 4 bytes.
// - ink start address moves in 8 KB granules.
// - start value zero places image at memory size minus 1024.
// - control value 0000 0001 enables the LCD hardware cursor.
// - start value n places image at memory size minus n times 8192.
// - codes pick colour 0, colour 1, background, inverted background.
// - the cursor image is 64 by 64 pixels at 2 bpp.
// - cursor position takes effect when Y high byte is written.
//
// Design decision made here: the APB interface to the registers.
module cursor_ink_overlay
(
  input  wire logic        core_clk,
  input  wire logic        resetn,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [11:0] paddr,
  input  wire logic [31:0] pwdata,
  output logic             pready,
  output logic [31:0]      prdata,
  output logic             pslverr,
  input  wire logic [21:0] mem_size,
  input  wire logic [10:0] disp_width,
  input  wire logic [10:0] disp_height,
  input  wire logic        dp_enable,
  input  wire logic        dp_color,
  input  wire logic        frame_start,
  input  wire logic [1:0]  pix_ready,
  input  wire logic [31:0] bg_pixels,
  output logic [1:0]       fetch_req,
  output logic [43:0]      fetch_addr,
  input  wire logic [1:0]  fetch_ack,
  input  wire logic [15:0] fetch_data,
  output logic [31:0]      out_pixels,
  output logic [1:0]       out_valid,
  output logic [21:0]      dp_base,
  output logic [21:0]      lcd_image_base,
  output logic [21:0]      tv_image_base,
  output logic [43:0]      cursor_pos,
  output logic [1:0]       pos_update
);

  // ****************************************************************
  // state
  // ****************************************************************
  typedef struct packed
  {
    logic [7:0]  ctrl;
    logic [7:0]  start;
    logic [15:0] c0;
    logic [15:0] c1;
    logic [3:0]  thr;
    logic [7:0]  xl;
    logic [7:0]  xh;
    logic [7:0]  yl;
    logic [10:0] pos_x;
    logic [10:0] pos_y;
    logic        upd;
    logic        req;
    logic [21:0] addr;
    logic [21:0] left;
    logic [4:0]  level;
    logic [3:0]  bitpos;
    logic [15:0] out_pix;
    logic        out_v;
  } chan_type;

  typedef struct packed
  {
    logic        pready;
    logic [31:0] prdata;
    logic        pslverr;
    logic [21:0] dp_base;
    logic [21:0] lcd_base;
    logic [21:0] tv_base;
    chan_type [1:0] ch;
  } state_type;

  state_type   s_q;
  state_type   s_d;

  // ****************************************************************
  // per-channel fifo of fetched words, and mixers
  // ****************************************************************
  logic [15:0] fifo_mem [2][overlay_pkg::FIFO_DEPTH];
  logic [3:0]  wr_ptr_q [2];
  logic [3:0]  rd_ptr_q [2];
  logic [15:0] mix_out [2];
  logic [15:0] head [2];
  logic [3:0]  eff_thr [2];
  logic        pop [2];
  logic        push [2];
  logic [7:0]  reg_idx;
  logic        wr_en;
  logic        rd_en;

  assign reg_idx = paddr[9:2];
  assign wr_en   = psel && penable && pwrite && !s_q.pready;
  assign rd_en   = psel && penable && !pwrite && !s_q.pready;

  genvar g;
  generate
    for (g = 0; g < 2; g++)
    begin : chan
      overlay_mix_if mif ();
      assign mif.mode       = s_q.ch[g].ctrl[1:0];
      assign mif.color0     = s_q.ch[g].c0;
      assign mif.color1     = s_q.ch[g].c1;
      assign mif.code_valid = s_q.ch[g].level != 5'h00;
      assign mif.code       = head[g][s_q.ch[g].bitpos +: 2];
      assign mif.bg_pixel   = bg_pixels[g*16 +: 16];
      assign mix_out[g]     = mif.out_pixel;
      assign head[g]        = fifo_mem[g][rd_ptr_q[g]];
      // zero threshold falls back to the built-in value
      assign eff_thr[g]     = (s_q.ch[g].thr == 4'h0) ? overlay_pkg::AUTO_THRESHOLD
                                                        : s_q.ch[g].thr;
      assign push[g]        = s_q.ch[g].req && fetch_ack[g];
      assign pop[g]         = pix_ready[g] && s_q.ch[g].level != 5'h00
                              && s_q.ch[g].bitpos == 4'he;
      overlay_mixer mixer (.mix(mif.mix));

      always_ff @(posedge core_clk or negedge resetn)
      begin
        if (!resetn)
        begin
          wr_ptr_q[g] <= 4'h0;
          rd_ptr_q[g] <= 4'h0;
        end
        else
        begin
          if (push[g])
          begin
            fifo_mem[g][wr_ptr_q[g]] <= fetch_data;
            wr_ptr_q[g] <= wr_ptr_q[g] + 4'h1;
          end
          if (pop[g])
            rd_ptr_q[g] <= rd_ptr_q[g] + 4'h1;
          if (frame_start)
          begin
            wr_ptr_q[g] <= 4'h0;
            rd_ptr_q[g] <= 4'h0;
          end
        end
      end
    end
  endgenerate

  // ****************************************************************
  // image base and length
  // ****************************************************************
  function automatic logic [21:0] image_base(input logic [7:0] start, input logic [21:0] size);
    logic [21:0] gran;
    gran = {1'b0, start, 13'h0000};
    if (start == 8'h00)
      image_base = size - overlay_pkg::CURSOR_BYTES;
    else
      image_base = size - gran;
  endfunction

  function automatic logic [21:0] image_len(input logic [1:0] mode, input logic [10:0] w,
                                            input logic [10:0] h);
    logic [21:0] area;
    area = {11'h000, w} * {11'h000, h};
    if (mode == overlay_pkg::MODE_INK)
      image_len = area >> 2;
    else
      image_len = overlay_pkg::CURSOR_BYTES;
  endfunction

  // ****************************************************************
  // next state
  // ****************************************************************
  always_comb
  begin
    logic [7:0]  idx;
    logic [7:0]  wb;
    logic [7:0]  rb;
    logic [21:0] area;
    idx = 8'h00;
    wb  = pwdata[7:0];
    rb  = 8'h00;
    area = {11'h000, disp_width} * {11'h000, disp_height};
    s_d = s_q;
    s_d.pready  = 1'b0;
    s_d.pslverr = 1'b0;
    // dual panel buffer sits at the very top of memory
    s_d.dp_base = dp_enable ? mem_size - ((area * (dp_color ? 22'(overlay_pkg::DP_FACTOR_COLOR)
                  : 22'(overlay_pkg::DP_FACTOR_MONO))) >> overlay_pkg::DP_DIV_SHIFT)
                  : mem_size;
    for (int c = 0; c < 2; c++)
    begin
      s_d.ch[c].upd = 1'b0;
      idx = (c == 0) ? overlay_pkg::IDX_LCD_CTRL : overlay_pkg::IDX_TV_CTRL;
      if (wr_en && reg_idx[7:4] == idx[7:4])
      begin
        case (reg_idx[3:0])
          4'h0: s_d.ch[c].ctrl = wb;
          4'h1: s_d.ch[c].start = wb;
          4'h2: s_d.ch[c].xl = wb;
          4'h3: s_d.ch[c].xh = wb;
          4'h4: s_d.ch[c].yl = wb;
          4'h5:
          begin
            s_d.ch[c].pos_x = {s_q.ch[c].xh[7], s_q.ch[c].xh[1:0], s_q.ch[c].xl};
            s_d.ch[c].pos_y = {wb[7], wb[1:0], s_q.ch[c].yl};
            s_d.ch[c].upd   = 1'b1;
          end
          4'h6: s_d.ch[c].c0[4:0]   = wb[4:0];
          4'h7: s_d.ch[c].c0[10:5]  = wb[5:0];
          4'h8: s_d.ch[c].c0[15:11] = wb[4:0];
          4'ha: s_d.ch[c].c1[4:0]   = wb[4:0];
          4'hb: s_d.ch[c].c1[10:5]  = wb[5:0];
          4'hc: s_d.ch[c].c1[15:11] = wb[4:0];
          4'he: s_d.ch[c].thr = wb[3:0];
          default: s_d.ch[c].ctrl = s_q.ch[c].ctrl;
        endcase
      end
      if (reg_idx[7:4] == idx[7:4])
      begin
        case (reg_idx[3:0])
          4'h0: rb = s_q.ch[c].ctrl;
          4'h1: rb = s_q.ch[c].start;
          4'h2: rb = s_q.ch[c].xl;
          4'h3: rb = s_q.ch[c].xh;
          4'h4: rb = s_q.ch[c].yl;
          4'h5: rb = {s_q.ch[c].pos_y[10], 5'h00, s_q.ch[c].pos_y[9:8]};
          4'h6: rb = {3'h0, s_q.ch[c].c0[4:0]};
          4'h7: rb = {2'h0, s_q.ch[c].c0[10:5]};
          4'h8: rb = {3'h0, s_q.ch[c].c0[15:11]};
          4'ha: rb = {3'h0, s_q.ch[c].c1[4:0]};
          4'hb: rb = {2'h0, s_q.ch[c].c1[10:5]};
          4'hc: rb = {3'h0, s_q.ch[c].c1[15:11]};
          4'he: rb = {4'h0, s_q.ch[c].thr};
          default: rb = rb;
        endcase
      end
      // fetch engine: refill below threshold while image bytes remain
      if (frame_start)
      begin
        s_d.ch[c].addr  = image_base(s_q.ch[c].start, mem_size);
        s_d.ch[c].left  = (s_q.ch[c].ctrl[1:0] == overlay_pkg::MODE_OFF) ? 22'h0
                          : image_len(s_q.ch[c].ctrl[1:0], disp_width, disp_height);
        s_d.ch[c].level = 5'h00;
        s_d.ch[c].req   = 1'b0;
        s_d.ch[c].bitpos = 4'h0;
      end
      else
      begin
        if (push[c])
        begin
          s_d.ch[c].addr = s_q.ch[c].addr + 22'h2;
          s_d.ch[c].left = (s_q.ch[c].left > 22'h2) ? s_q.ch[c].left - 22'h2 : 22'h0;
        end
        s_d.ch[c].level = s_q.ch[c].level + {4'h0, push[c]} - {4'h0, pop[c]};
        s_d.ch[c].req = s_d.ch[c].left != 22'h0
                        && s_d.ch[c].level < {1'b0, eff_thr[c]};
        if (pix_ready[c] && s_q.ch[c].level != 5'h00)
          s_d.ch[c].bitpos = s_q.ch[c].bitpos + 4'h2;
      end
      s_d.ch[c].out_v   = pix_ready[c];
      s_d.ch[c].out_pix = mix_out[c];
    end
    s_d.lcd_base = image_base(s_d.ch[0].start, mem_size);
    s_d.tv_base  = image_base(s_d.ch[1].start, mem_size);
    if (psel && penable && !s_q.pready)
    begin
      s_d.pready  = 1'b1;
      s_d.prdata  = rd_en ? {24'h0, rb} : s_q.prdata;
      s_d.pslverr = paddr[11:10] != 2'h0;
    end
  end

  always_ff @(posedge core_clk or negedge resetn)
  begin
    if (!resetn)
      s_q <= '0;
    else
      s_q <= s_d;
  end

  // ****************************************************************
  // outputs
  // ****************************************************************
  assign pready         = s_q.pready;
  assign prdata         = s_q.prdata;
  assign pslverr        = s_q.pslverr;
  assign dp_base        = s_q.dp_base;
  assign lcd_image_base = s_q.lcd_base;
  assign tv_image_base  = s_q.tv_base;
  assign fetch_req      = {s_q.ch[1].req, s_q.ch[0].req};
  assign fetch_addr     = {s_q.ch[1].addr, s_q.ch[0].addr};
  assign out_pixels     = {s_q.ch[1].out_pix, s_q.ch[0].out_pix};
  assign out_valid      = {s_q.ch[1].out_v, s_q.ch[0].out_v};
  assign cursor_pos     = {s_q.ch[1].pos_y, s_q.ch[1].pos_x, s_q.ch[0].pos_y, s_q.ch[0].pos_x};
  assign pos_update     = {s_q.ch[1].upd, s_q.ch[0].upd};

  // ****************************************************************
  // checks
  // ****************************************************************
  apb_one_wait_a: assert property (@(posedge core_clk) disable iff (!resetn)
    psel && penable && !pready |=> pready)
    else $error("apb answer late");

  color_write_a: assert property (@(posedge core_clk) disable iff (!resetn)
    wr_en && reg_idx == overlay_pkg::IDX_TV_C0_GREEN |=> s_q.ch[1].c0[10:5] == $past(pwdata[5:0]))
    else $error("tv colour 0 green lost");

  color1_write_a: assert property (@(posedge core_clk) disable iff (!resetn)
    wr_en && reg_idx == overlay_pkg::IDX_TV_C1_RED |=> s_q.ch[1].c1[15:11] == $past(pwdata[4:0]))
    else $error("tv colour 1 red lost");

  fetch_stop_a: assert property (@(posedge core_clk) disable iff (!resetn)
    s_q.ch[0].left == 22'h0 |-> !fetch_req[0])
    else $error("fetch past image end");

  fifo_fill_a: assert property (@(posedge core_clk) disable iff (!resetn)
    fetch_req[0] |-> s_q.ch[0].level < {1'b0, eff_thr[0]})
    else $error("fetch above threshold");

  auto_thr_a: assert property (@(posedge core_clk) disable iff (!resetn)
    s_q.ch[1].thr == 4'h0 |-> eff_thr[1] == overlay_pkg::AUTO_THRESHOLD)
    else $error("auto threshold missing");

  pos_hold_a: assert property (@(posedge core_clk) disable iff (!resetn)
    !(wr_en && reg_idx == 8'h75) |=> $stable(s_q.ch[0].pos_y))
    else $error("cursor moved early");

  bypass_a: assert property (@(posedge core_clk) disable iff (!resetn)
    s_q.ch[0].ctrl[1:0] == overlay_pkg::MODE_OFF |-> mix_out[0] == bg_pixels[15:0])
    else $error("disabled overlay altered pixel");

endmodule

// ==== cursor_ink_overlay_test.sv ====
// bench: overlay registers, image placement, fetch counts and mixing
module cursor_ink_overlay_test;
  timeunit 1ns;
  timeprecision 1ps;
  typedef struct packed {logic [1:0] m; logic [15:0] f; logic [15:0] e;} row_type;
  localparam logic [15:0] C0 = {5'h11, 6'h2a, 5'h05};
  localparam logic [15:0] C1 = {5'h0a, 6'h15, 5'h1a};
  localparam logic [15:0] BG = 16'h3c96;
  logic        core_clk, resetn, psel, penable, pwrite, pready, pslverr;
  logic        dp_enable, dp_color, frame_start, slow, err;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, bg_pixels, out_pixels, rd;
  logic [21:0] mem_size, dp_base, lcd_image_base, tv_image_base, first_addr;
  logic [10:0] disp_width, disp_height;
  logic [1:0]  pix_ready, fetch_req, fetch_ack, out_valid, pos_update;
  logic [43:0] fetch_addr, cursor_pos;
  logic [15:0] fetch_data, fill_word;
  int          n_mismatch, compares, cycles, acks, upd;
  row_type     rows [5] = '{'{overlay_pkg::MODE_OFF, 16'hffff, BG},
    '{overlay_pkg::MODE_INK, 16'h0000, C0}, '{overlay_pkg::MODE_INK, 16'h5555, C1},
    '{overlay_pkg::MODE_INK, 16'haaaa, BG}, '{overlay_pkg::MODE_INK, 16'hffff, ~BG}};
  logic [15:0] regs [8] = '{{overlay_pkg::IDX_LCD_FIFO_THR, 8'h0c},
    {overlay_pkg::IDX_TV_C0_BLUE, 8'h1f}, {overlay_pkg::IDX_TV_C0_GREEN, 8'h3f},
    {overlay_pkg::IDX_TV_C0_RED, 8'h15}, {overlay_pkg::IDX_TV_C1_BLUE, 8'h0a},
    {overlay_pkg::IDX_TV_C1_GREEN, 8'h2b}, {overlay_pkg::IDX_TV_C1_RED, 8'h1e},
    {overlay_pkg::IDX_TV_FIFO_THR, 8'h07}};

  cursor_ink_overlay dut (.core_clk, .resetn, .psel, .penable, .pwrite, .paddr, .pwdata,
    .pready, .prdata, .pslverr, .mem_size, .disp_width, .disp_height, .dp_enable,
    .dp_color, .frame_start, .pix_ready, .bg_pixels, .fetch_req, .fetch_addr, .fetch_ack,
    .fetch_data, .out_pixels, .out_valid, .dp_base, .lcd_image_base, .tv_image_base,
    .cursor_pos, .pos_update);
  overlay_mem_model mem (.core_clk, .resetn, .fetch_req, .fill_word, .slow, .fetch_ack,
    .fetch_data);

  // ****************************************************************
  // clock, monitors, timeout
  // ****************************************************************
  initial
  begin
    core_clk = 1'b0;
    forever #5 core_clk = ~core_clk;
  end
  always @(posedge core_clk)
  begin
    cycles++;
    if (fetch_ack[1] === 1'b1 && acks == 0)
      first_addr = fetch_addr[43:22];
    if (fetch_ack[1] === 1'b1)
      acks++;
    if (pos_update[0] === 1'b1)
      upd++;
    if (cycles == 20000)
    begin
      n_mismatch++;
      summarize();
    end
  end

  // ****************************************************************
  // tasks
  // ****************************************************************
  task automatic check(string what, logic [43:0] seen, logic [43:0] exp);
    compares++;
    if (seen !== exp)
    begin
      n_mismatch++;
      $display("[ERR] %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic apb(logic wr, logic [11:0] a, logic [7:0] wd);
    @(posedge core_clk);
    psel   <= 1'b1;
    pwrite <= wr;
    paddr  <= a;
    pwdata <= {24'h000000, wd};
    @(posedge core_clk);
    penable <= 1'b1;
    @(posedge core_clk);
    while (pready !== 1'b1)
      @(posedge core_clk);
    rd  = prdata;
    err = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic wreg(logic [7:0] idx, logic [7:0] v);
    apb(1'b1, {2'h0, idx, 2'h0}, v);
  endtask
  task automatic frame(logic [15:0] f);
    @(posedge core_clk);
    fill_word   <= f;
    frame_start <= 1'b1;
    acks = 0;
    @(posedge core_clk);
    frame_start <= 1'b0;
  endtask
  task automatic summarize();
    $display("comparisons %0d mismatches %0d", compares, n_mismatch);
    if (n_mismatch == 0 && compares > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask

  // ****************************************************************
  // main sequence
  // ****************************************************************
  initial
  begin
    {resetn, psel, penable, pwrite, frame_start, slow, dp_enable, dp_color} = 8'h03;
    {paddr, pwdata, pix_ready, fill_word} = '0;
    {mem_size, disp_width, disp_height, bg_pixels} = {22'h200000, 11'd16, 11'd8, BG, BG};
    repeat (2) @(posedge core_clk);
    resetn <= 1'b1;
    foreach (regs[i])
    begin
      apb(1'b0, {2'h0, regs[i][15:8], 2'h0}, 8'h00);
      check("reset value", rd[7:0], 8'h00);
      wreg(regs[i][15:8], regs[i][7:0]);
      apb(1'b0, {2'h0, regs[i][15:8], 2'h0}, 8'h00);
      check("readback", rd[7:0], regs[i][7:0]);
    end
    wreg(8'h89, 8'h55);
    apb(1'b0, 12'h224, 8'h00);
    check("unmapped", rd, 32'h0);
    apb(1'b0, 12'h400, 8'h00);
    check("slave error", err, 1'b1);
    check("dp base color", dp_base, 22'h200000 - 22'd32);
    dp_color <= 1'b0;
    repeat (3) @(posedge core_clk);
    check("dp base mono", dp_base, 22'h200000 - 22'd8);
    wreg(overlay_pkg::IDX_LCD_START, 8'h00);
    check("lcd base", lcd_image_base, 22'h200000 - 22'h000400);
    wreg(overlay_pkg::IDX_TV_START, 8'h0a);
    check("tv base", tv_image_base, 22'h200000 - 22'd81920);
    wreg(overlay_pkg::IDX_TV_C0_BLUE, 8'h05);
    wreg(overlay_pkg::IDX_TV_C0_GREEN, 8'h2a);
    wreg(overlay_pkg::IDX_TV_C0_RED, 8'h11);
    wreg(overlay_pkg::IDX_TV_C1_BLUE, 8'h1a);
    wreg(overlay_pkg::IDX_TV_C1_GREEN, 8'h15);
    wreg(overlay_pkg::IDX_TV_C1_RED, 8'h0a);
    wreg(overlay_pkg::IDX_TV_FIFO_THR, 8'h00);
    foreach (rows[i])
    begin
      wreg(overlay_pkg::IDX_TV_CTRL, {6'h00, rows[i].m});
      frame(rows[i].f);
      for (int k = 0; k < 40 && acks < 2; k++)
        @(posedge core_clk);
      pix_ready <= 2'h2;
      @(posedge core_clk);
      pix_ready <= 2'h0;
      #1;
      check("valid", out_valid[1], 1'b1);
      check("pixel", out_pixels[31:16], rows[i].e);
    end
    slow <= 1'b1;
    frame(16'h5555);
    for (int k = 0; k < 400; k++)
      @(posedge core_clk) pix_ready <= (k < 128) ? 2'h2 : 2'h0;
    check("ink words", acks, 16);
    check("ink start", first_addr, 22'h200000 - 22'd81920);
    disp_width  <= 11'd64;
    disp_height <= 11'd64;
    wreg(overlay_pkg::IDX_TV_FIFO_THR, 8'h03);
    frame(16'h5555);
    repeat (100) @(posedge core_clk);
    check("thr fill", acks, 3);
    wreg(overlay_pkg::IDX_TV_FIFO_THR, 8'h00);
    frame(16'h5555);
    repeat (100) @(posedge core_clk);
    check("auto fill", acks, 8);
    wreg(overlay_pkg::IDX_LCD_CTRL, 8'h01);
    frame(16'h0000);
    for (int k = 0; k < 40 && fetch_req[0] !== 1'b1; k++)
      @(posedge core_clk);
    check("lcd fetch", fetch_addr[21:0], 22'h200000 - 22'h000400);
    upd = 0;
    wreg(8'h72, 8'h23);
    wreg(8'h73, 8'h81);
    wreg(8'h74, 8'h45);
    check("pos held", {upd[0], cursor_pos[21:0]}, 23'h0);
    wreg(8'h75, 8'h02);
    @(posedge core_clk);
    check("pos taken", {upd[0], cursor_pos[21:0]}, {1'b1, 11'h245, 11'h523});
    summarize();
  end
endmodule

// ==== overlay_mem_model.sv ====
// display buffer model answering overlay word fetches
module overlay_mem_model
(
  input  wire logic        core_clk,
  input  wire logic        resetn,
  input  wire logic [1:0]  fetch_req,
  input  wire logic [15:0] fill_word,
  input  wire logic        slow,
  output logic [1:0]       fetch_ack,
  output logic [15:0]      fetch_data
);
  timeunit 1ns;
  timeprecision 1ps;
  int wait_q;
  always @(posedge core_clk or negedge resetn)
  begin
    if (!resetn)
    begin
      fetch_ack  <= 2'h0;
      fetch_data <= 16'h0000;
      wait_q     <= 0;
    end
    else if (fetch_ack != 2'h0)
    begin
      fetch_ack  <= 2'h0;
      fetch_data <= ~fetch_data;
    end
    else if (fetch_req != 2'h0 && wait_q < (slow ? 3 : 0))
      wait_q <= wait_q + 1;
    else if (fetch_req != 2'h0)
    begin
      fetch_ack  <= fetch_req[0] ? 2'h1 : 2'h2;
      fetch_data <= fill_word;
      wait_q     <= 0;
    end
    else
      fetch_data <= ~fetch_data;
  end
endmodule

// ==== overlay_mix_if.sv ====
// interface: one channel's settings travelling from the top to its mixer
interface overlay_mix_if;
  logic [1:0]  mode;
  logic [15:0] color0;
  logic [15:0] color1;
  logic [1:0]  code;
  logic        code_valid;
  logic [15:0] bg_pixel;
  logic [15:0] out_pixel;
  modport top (output mode, color0, color1, code, code_valid, bg_pixel, input out_pixel);
  modport mix (input mode, color0, color1, code, code_valid, bg_pixel, output out_pixel);
endinterface

// ==== overlay_mixer.sv ====
// mixer: merges one 2 bpp overlay code with the background pixel
module overlay_mixer
(
  overlay_mix_if.mix  mix
);

  always_comb
  begin
    mix.out_pixel = mix.bg_pixel;
    if (mix.mode != overlay_pkg::MODE_OFF && mix.code_valid)
    begin
      case (mix.code)
        overlay_pkg::CODE_COLOR0:     mix.out_pixel = mix.color0;
        overlay_pkg::CODE_COLOR1:     mix.out_pixel = mix.color1;
        overlay_pkg::CODE_BACKGROUND: mix.out_pixel = mix.bg_pixel;
        default:                      mix.out_pixel = ~mix.bg_pixel;
      endcase
    end
  end

endmodule

// ==== overlay_pkg.sv ====
// package: register map, field layout and constants of the cursor/ink overlay
package overlay_pkg;

  // ****************************************************************
  // register indices (index of printed map, byte address = 4x)
  // ****************************************************************
  localparam logic [7:0]  IDX_LCD_CTRL       = 8'h70;
  localparam logic [7:0]  IDX_LCD_START      = 8'h71;
  localparam logic [7:0]  IDX_LCD_C0_BLUE    = 8'h76;
  localparam logic [7:0]  IDX_LCD_C0_GREEN   = 8'h77;
  localparam logic [7:0]  IDX_LCD_C0_RED     = 8'h78;
  localparam logic [7:0]  IDX_LCD_C1_BLUE    = 8'h7a;
  localparam logic [7:0]  IDX_LCD_C1_GREEN   = 8'h7b;
  localparam logic [7:0]  IDX_LCD_C1_RED     = 8'h7c;
  localparam logic [7:0]  IDX_LCD_FIFO_THR   = 8'h7e;
  localparam logic [7:0]  IDX_TV_CTRL        = 8'h80;
  localparam logic [7:0]  IDX_TV_START       = 8'h81;
  localparam logic [7:0]  IDX_TV_C0_BLUE     = 8'h86;
  localparam logic [7:0]  IDX_TV_C0_GREEN    = 8'h87;
  localparam logic [7:0]  IDX_TV_C0_RED      = 8'h88;
  localparam logic [7:0]  IDX_TV_C1_BLUE     = 8'h8a;
  localparam logic [7:0]  IDX_TV_C1_GREEN    = 8'h8b;
  localparam logic [7:0]  IDX_TV_C1_RED      = 8'h8c;
  localparam logic [7:0]  IDX_TV_FIFO_THR    = 8'h8e;

  // ****************************************************************
  // field widths, reset values, modes
  // ****************************************************************
  localparam int          BLUE_W             = 5;
  localparam int          GREEN_W            = 6;
  localparam int          RED_W              = 5;
  localparam int          THR_W              = 4;
  localparam int          ADDR_W             = 22;
  localparam logic [7:0]  RESET_BYTE         = 8'h00;
  localparam logic [1:0]  MODE_OFF           = 2'h0;
  localparam logic [1:0]  MODE_CURSOR        = 2'h1;
  localparam logic [1:0]  MODE_INK           = 2'h2;
  localparam logic [1:0]  CODE_COLOR0        = 2'h0;
  localparam logic [1:0]  CODE_COLOR1        = 2'h1;
  localparam logic [1:0]  CODE_BACKGROUND    = 2'h2;
  localparam logic [1:0]  CODE_INVERT        = 2'h3;

  // ****************************************************************
  // memory layout constants
  // ****************************************************************
  localparam logic [ADDR_W-1:0] CURSOR_BYTES = 22'h000400;
  localparam int          GRANULE_SHIFT      = 13;
  localparam logic [3:0]  AUTO_THRESHOLD     = 4'h8;
  localparam int          FIFO_DEPTH         = 16;
  localparam int          DP_DIV_SHIFT       = 4;
  localparam logic [2:0]  DP_FACTOR_COLOR    = 3'h4;
  localparam logic [2:0]  DP_FACTOR_MONO     = 3'h1;

endpackage
